//--- ncq_pkg.sv
/*
 * Shared constants and carrier types for the queued-command frame builder:
 * frame layouts, register offsets and reset values.
 * Assumes a 32-bit word-wide link layer beneath and an APB master above.
 */
`default_nettype none

package ncq_pkg;

    // ------------------------------------------------------------------
    // Frame layouts
    // ------------------------------------------------------------------
    localparam int          NCQ_TAG_W          = 5;
    localparam int          NCQ_MASK_W         = 32;
    localparam logic [7:0]  NCQ_TYPE_DSETUP    = 8'h41;
    localparam logic [7:0]  NCQ_TYPE_SDB       = 8'hA1;
    localparam logic [2:0]  NCQ_DSETUP_LAST    = 3'h6;
    localparam logic [2:0]  NCQ_SDB_LAST       = 3'h1;
    localparam logic [2:0]  NCQ_W_BUFID_LO     = 3'h1;
    localparam logic [2:0]  NCQ_W_OFFSET       = 3'h4;
    localparam logic [2:0]  NCQ_W_COUNT        = 3'h5;
    localparam int          NCQ_BIT_DIR        = 13;
    localparam int          NCQ_BIT_IRQ        = 14;
    localparam int          NCQ_BIT_AUTO       = 15;
    localparam int          NCQ_BIT_SDB_IRQ    = 14;
    localparam int          NCQ_STAT_LSB       = 16;
    localparam int          NCQ_ERR_LSB        = 24;
    localparam logic [7:0]  NCQ_STATUS_OK      = 8'h40;
    localparam logic [7:0]  NCQ_ERROR_OK       = 8'h00;
    localparam logic [7:0]  NCQ_STAT_FIELD_MSK = 8'h77;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  NCQ_REG_CTRL       = 8'h00;
    localparam logic [7:0]  NCQ_REG_STATUS     = 8'h04;
    localparam logic [7:0]  NCQ_REG_PENDING    = 8'h08;
    localparam logic [7:0]  NCQ_REG_SDB_COUNT  = 8'h0C;
    localparam int          NCQ_CTRL_OFS_EN    = 0;
    localparam int          NCQ_CTRL_SDB_AUTO  = 1;
    localparam int          NCQ_CTRL_SDB_IRQ   = 2;
    localparam int          NCQ_CTRL_FLUSH     = 3;
    localparam logic [2:0]  NCQ_CTRL_RESET     = 3'h6;
    localparam int          NCQ_ST_OCCUPIED    = 0;
    localparam int          NCQ_ST_ACTIVE      = 1;
    localparam int          NCQ_ST_ZERO_CNT    = 2;
    localparam int          NCQ_ST_FAIL_SEEN   = 3;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  dir;
        logic                  auto_act;
        logic [NCQ_TAG_W-1:0]  tag;
        logic [31:0]           offset;
        logic [31:0]           count;
    } ncq_dma_req_t;

    typedef struct packed {
        logic [NCQ_TAG_W-1:0]  tag;
        logic                  ok;
    } ncq_cmpl_t;

    typedef struct packed {
        logic [31:0]           data;
        logic                  last;
    } ncq_word_t;

    typedef enum logic [1:0] {
        NCQ_IDLE = 2'b00,
        NCQ_DMA  = 2'b01,
        NCQ_SDB  = 2'b10
    } ncq_state_t;

endpackage

`default_nettype wire

//--- ncq_fis_framer.sv
/*
 * Device-side builder of the DMA setup frame and the set-device-bits
 * completion frame for queued commands, with an APB register slave.
 * Assumes the link layer takes one 32-bit word per valid/ready handshake
 * and that the command layer reports each finished tag once.
 */
// Functional notes
// - Direction bit one means device to host
// - Auto-activate zero for device-to-host transfers
// - Tag in low five buffer identifier bits
// - Other buffer identifier bits sent zero
// - Nonzero offset only when feature enabled
// - Data runs upward from offset in buffer
// - Exact transfer count, never zero
// - Setup frame interrupt bit always zero
// - Reserved setup fields sent zero
// - Mask bit n belongs to tag n
// - Completion mask is the last word
// - First word carries type A1h, status, flags
// - Report every tag completed since last report
// - Success: error zero, ready set, fault clear
// - Busy zero means another command accepted
// - Several completions may share one frame
// - Only successful commands enter the mask
// - No handshake, no notification lost
// - Tags run zero to thirty-one
`timescale 1ns/100ps
`default_nettype none

module ncq_fis_framer
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 dma_req_valid,
    input  wire ncq_pkg::ncq_dma_req_t dma_req,
    output logic                      dma_req_ready,
    input  wire logic                 cmpl_valid,
    input  wire ncq_pkg::ncq_cmpl_t   cmpl,
    input  wire logic                 queue_full,
    output logic                      device_occupied_flag,
    output logic                      tx_valid,
    output ncq_pkg::ncq_word_t        tx_word,
    input  wire logic                 tx_ready
);
    import ncq_pkg::*;

    // ------------------------------------------------------------------
    // Frame word builder
    // ------------------------------------------------------------------
    function automatic logic [31:0] frame_word
    (
        input logic                  is_sdb,
        input logic [2:0]            idx,
        input ncq_dma_req_t          req,
        input logic [NCQ_MASK_W-1:0] mask,
        input logic                  sdb_irq,
        input logic                  ofs_en
    );
        logic [31:0] w;
        w = '0;
        if (is_sdb)
        begin
            if (idx == NCQ_SDB_LAST)
            begin
                w = mask;
            end
            else
            begin
                w[7:0] = NCQ_TYPE_SDB;
                w[NCQ_BIT_SDB_IRQ] = sdb_irq;
                // Status byte carries only the high and low triplets
                w[NCQ_STAT_LSB +: 8] = NCQ_STATUS_OK & NCQ_STAT_FIELD_MSK;
                w[NCQ_ERR_LSB +: 8] = NCQ_ERROR_OK;
            end
        end
        else
        begin
            unique case (idx)
                3'h0:
                begin
                    w[7:0] = NCQ_TYPE_DSETUP;
                    w[NCQ_BIT_DIR] = req.dir;
                    w[NCQ_BIT_IRQ] = 1'b0;
                    w[NCQ_BIT_AUTO] = req.auto_act & ~req.dir;
                end
                NCQ_W_BUFID_LO:
                begin
                    w[NCQ_TAG_W-1:0] = req.tag;
                end
                NCQ_W_OFFSET:
                begin
                    // Offset passes through only with ofs_en set, else zero; data walks upward from it
                    w = ofs_en ? req.offset : 32'h0000_0000;
                end
                NCQ_W_COUNT:
                begin
                    w = req.count;
                end
                default:
                begin
                    w = '0;
                end
            endcase
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    ncq_state_t              state;
    logic [2:0]              idx;
    ncq_dma_req_t            req_hold;
    logic [NCQ_MASK_W-1:0]   pending;
    logic [NCQ_MASK_W-1:0]   sent_mask;
    logic                    ofs_en;
    logic                    sdb_auto;
    logic                    sdb_irq;
    logic                    flush_pend;
    logic                    zero_cnt_err;
    logic                    fail_seen;
    logic [31:0]             sdb_count;
    logic                    sdb_go;
    logic                    sdb_launch;
    logic                    dma_take;
    logic                    load;
    logic                    last_word;
    logic                    wr_en;
    logic                    rd_en;
    logic                    addr_ok;
    logic [NCQ_MASK_W-1:0]   cmpl_set;

    assign sdb_go     = (pending != '0) && (sdb_auto || flush_pend);
    assign sdb_launch = (state == NCQ_IDLE) && sdb_go;
    // Completions go first so a steady setup stream cannot hide them
    assign dma_req_ready = (state == NCQ_IDLE) && !sdb_go;
    assign dma_take   = dma_req_valid && dma_req_ready;
    assign load       = (state != NCQ_IDLE) && (!tx_valid || tx_ready);
    assign last_word  = (state == NCQ_SDB) ? (idx == NCQ_SDB_LAST) : (idx == NCQ_DSETUP_LAST);
    assign wr_en      = psel && penable && pwrite;
    assign rd_en      = psel && !pwrite;
    assign addr_ok    = (paddr == ADDR_W'(NCQ_REG_CTRL)) || (paddr == ADDR_W'(NCQ_REG_STATUS))
                     || (paddr == ADDR_W'(NCQ_REG_PENDING)) || (paddr == ADDR_W'(NCQ_REG_SDB_COUNT));
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !addr_ok;

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state     <= NCQ_IDLE;
            idx       <= 3'h0;
            req_hold  <= '0;
            sent_mask <= '0;
        end
        else
        begin
            unique case (state)
                NCQ_IDLE:
                begin
                    idx <= 3'h0;
                    if (sdb_launch)
                    begin
                        state     <= NCQ_SDB;
                        sent_mask <= pending;
                    end
                    else if (dma_take && (dma_req.count != 32'h0000_0000))
                    begin
                        state    <= NCQ_DMA;
                        req_hold <= dma_req;
                    end
                end
                NCQ_DMA, NCQ_SDB:
                begin
                    if (load)
                    begin
                        if (last_word)
                        begin
                            state <= NCQ_IDLE;
                        end
                        else
                        begin
                            idx <= idx + 3'h1;
                        end
                    end
                end
                default:
                begin
                    state <= NCQ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Link output
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            tx_valid <= 1'b0;
            tx_word  <= '0;
        end
        else if (load)
        begin
            tx_valid     <= 1'b1;
            tx_word.data <= frame_word(state == NCQ_SDB, idx, req_hold, sent_mask, sdb_irq, ofs_en);
            tx_word.last <= last_word;
        end
        else if (tx_ready)
        begin
            tx_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pending completions
    // ------------------------------------------------------------------
    always_comb
    begin
        cmpl_set = '0;
        if (cmpl_valid && cmpl.ok)
        begin
            cmpl_set[cmpl.tag] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pending <= '0;
        end
        else if (sdb_launch)
        begin
            // New success in the launch cycle stays for the next frame
            pending <= (pending & ~pending) | cmpl_set;
        end
        else
        begin
            pending <= pending | cmpl_set;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sdb_count <= 32'h0000_0000;
        end
        else if (sdb_launch)
        begin
            sdb_count <= sdb_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            device_occupied_flag <= 1'b1;
        end
        else
        begin
            device_occupied_flag <= queue_full;
        end
    end

    // ------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            {sdb_irq, sdb_auto, ofs_en} <= NCQ_CTRL_RESET;
        end
        else if (wr_en && pstrb[0] && (paddr == ADDR_W'(NCQ_REG_CTRL)))
        begin
            ofs_en   <= pwdata[NCQ_CTRL_OFS_EN];
            sdb_auto <= pwdata[NCQ_CTRL_SDB_AUTO];
            sdb_irq  <= pwdata[NCQ_CTRL_SDB_IRQ];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            flush_pend <= 1'b0;
        end
        else if (wr_en && pstrb[0] && (paddr == ADDR_W'(NCQ_REG_CTRL)) && pwdata[NCQ_CTRL_FLUSH])
        begin
            flush_pend <= 1'b1;
        end
        else if (sdb_launch)
        begin
            flush_pend <= 1'b0;
        end
    end

    // Sticky flags: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            zero_cnt_err <= 1'b0;
            fail_seen    <= 1'b0;
        end
        else
        begin
            if (dma_take && (dma_req.count == 32'h0000_0000))
            begin
                zero_cnt_err <= 1'b1;
            end
            else if (wr_en && pstrb[0] && (paddr == ADDR_W'(NCQ_REG_STATUS)) && pwdata[NCQ_ST_ZERO_CNT])
            begin
                zero_cnt_err <= 1'b0;
            end
            if (cmpl_valid && !cmpl.ok)
            begin
                fail_seen <= 1'b1;
            end
            else if (wr_en && pstrb[0] && (paddr == ADDR_W'(NCQ_REG_STATUS)) && pwdata[NCQ_ST_FAIL_SEEN])
            begin
                fail_seen <= 1'b0;
            end
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_en)
        begin
            if (paddr == ADDR_W'(NCQ_REG_CTRL))
            begin
                prdata[NCQ_CTRL_OFS_EN]   = ofs_en;
                prdata[NCQ_CTRL_SDB_AUTO] = sdb_auto;
                prdata[NCQ_CTRL_SDB_IRQ]  = sdb_irq;
            end
            else if (paddr == ADDR_W'(NCQ_REG_STATUS))
            begin
                prdata[NCQ_ST_OCCUPIED]  = device_occupied_flag;
                prdata[NCQ_ST_ACTIVE]    = (state != NCQ_IDLE) || tx_valid;
                prdata[NCQ_ST_ZERO_CNT]  = zero_cnt_err;
                prdata[NCQ_ST_FAIL_SEEN] = fail_seen;
            end
            else if (paddr == ADDR_W'(NCQ_REG_PENDING))
            begin
                prdata = pending;
            end
            else if (paddr == ADDR_W'(NCQ_REG_SDB_COUNT))
            begin
                prdata = sdb_count;
            end
        end
    end

endmodule

`default_nettype wire

//--- ncq_fis_framer_properties.sv
/* Concurrent checks on the frame builder's link-side outputs.
   Bound into ncq_fis_framer; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module ncq_framer_props
(
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire logic                  dma_req_valid,
    input wire ncq_pkg::ncq_dma_req_t dma_req,
    input wire logic                  dma_req_ready,
    input wire logic                  cmpl_valid,
    input wire ncq_pkg::ncq_cmpl_t    cmpl,
    input wire logic                  queue_full,
    input wire logic                  device_occupied_flag,
    input wire logic                  tx_valid,
    input wire ncq_pkg::ncq_word_t    tx_word,
    input wire logic                  tx_ready
);
    import ncq_pkg::*;

    // --------------------
    // Frame tracking
    // --------------------
    logic [2:0]   widx;
    logic [7:0]   ftype;
    logic [7:0]   cur_type;
    logic         dma_w;
    logic         sdb_w;
    ncq_dma_req_t hreq;
    logic [31:0]  owed;
    logic [6:0]   age;

    assign cur_type = (widx == 3'h0) ? tx_word.data[7:0] : ftype;
    assign dma_w    = tx_valid && cur_type == NCQ_TYPE_DSETUP;
    assign sdb_w    = tx_valid && cur_type == NCQ_TYPE_SDB;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            widx <= 3'h0;
        else if (tx_valid && tx_ready)
            widx <= tx_word.last ? 3'h0 : widx + 3'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (tx_valid && widx == 3'h0)
            ftype <= tx_word.data[7:0];
    end

    // Kept from the take, so later words can be judged
    always_ff @(posedge sys_clk)
    begin
        if (dma_req_valid && dma_req_ready)
            hreq <= dma_req;
    end

    // Successes not yet reported; age counts only cycles with tx_ready high
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            owed <= 32'h0;
        else
            owed <= (owed & ~((sdb_w && widx == 3'h1 && tx_ready) ? tx_word.data : 32'h0))
                    | ((cmpl_valid && cmpl.ok) ? 32'h1 << cmpl.tag : 32'h0);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || owed == 32'h0 || (sdb_w && tx_ready && tx_word.last))
            age <= 7'h0;
        else if (tx_ready)
            age <= age + 7'h1;
    end

    // --------------------
    // Properties
    // --------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    dir_bit_a:
    assert property (dma_w && widx == 3'h0 |-> tx_word.data[31:8] ==
        {16'h0000, hreq.auto_act & ~hreq.dir, 1'b0, hreq.dir, 5'h00}) else $error("setup header wrong");
    buf_id_a:
    assert property (dma_w && widx == 3'h1 |-> tx_word.data == {27'h0, hreq.tag}) else $error("buffer id wrong");
    xfer_cnt_a:
    assert property (dma_w && widx == 3'h5 |-> tx_word.data == hreq.count && tx_word.data != 32'h0)
        else $error("transfer count wrong");
    res_words_a:
    assert property (dma_w && (widx == 3'h2 || widx == 3'h3 || widx == 3'h6) |->
        tx_word.data == 32'h0 && tx_word.last == (widx == 3'h6)) else $error("reserved word wrong");
    sdb_head_a:
    assert property (sdb_w && widx == 3'h0 |-> {tx_word.data[31:15], tx_word.data[13:8]} ==
        {NCQ_ERROR_OK, NCQ_STATUS_OK, 7'h00} && !tx_word.last) else $error("completion head wrong");
    mask_word_a:
    assert property (sdb_w && widx == 3'h1 |-> tx_word.last && (tx_word.data & ~owed) == 32'h0)
        else $error("completion mask wrong");
    hold_word_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word)) else $error("word dropped");
    occupied_a:
    assert property (!$past(reset) |-> device_occupied_flag == $past(queue_full)) else $error("occupied flag wrong");
    owed_age_a:
    assert property (age < 7'h3C) else $error("completion not reported");
endmodule

bind ncq_fis_framer ncq_framer_props u_ncq_framer_props
(
    .sys_clk(sys_clk), .reset(reset), .dma_req_valid(dma_req_valid), .dma_req(dma_req),
    .dma_req_ready(dma_req_ready), .cmpl_valid(cmpl_valid), .cmpl(cmpl), .queue_full(queue_full),
    .device_occupied_flag(device_occupied_flag), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready)
);

`default_nettype wire

//--- ncq_host_model.sv
/* Behavioural host adapter at the link side: takes frame words,
   keeps shadow registers. Assumes one word per valid/ready handshake. */
`timescale 1ns/100ps
`default_nettype none

module ncq_host_model
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 stall,
    input  wire logic                 issue_valid,
    input  wire logic [4:0]           issue_tag,
    input  wire logic                 tx_valid,
    input  wire ncq_pkg::ncq_word_t   tx_word,
    output logic                      tx_ready
);
    import ncq_pkg::*;

    logic [31:0] rx[$];
    logic [31:0] shadow_act;
    logic [7:0]  shadow_stat;
    logic [7:0]  shadow_err;
    logic [31:0] head;
    logic        first;
    logic [2:0]  cyc;

    // Slow mode takes a word only every other cycle
    assign tx_ready = !stall || cyc[0];

    // Non-blocking so the framer never races the ready it samples
    always_ff @(posedge sys_clk)
    begin
        cyc <= reset ? 3'h0 : cyc + 3'h1;
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            first = 1'b1;
            shadow_act = 32'h0;
        end
        else
        begin
            if (issue_valid)
                shadow_act = shadow_act | (32'h1 << issue_tag);
            if (tx_valid && tx_ready)
            begin
                rx.push_back(tx_word.data);
                if (first)
                    head = tx_word.data;
                if (first && head[7:0] == NCQ_TYPE_SDB)
                    {shadow_err, shadow_stat} = tx_word.data[31:16];
                if (!first && head[7:0] == NCQ_TYPE_SDB)
                    shadow_act = shadow_act & ~tx_word.data;
                first = tx_word.last;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for the queued-command frame builder.
   Needs ncq_pkg, the framer, its checker and the host model. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, a) begin checked++; if ((a) !== (x)) begin error_cnt++; $display("Error %s expected %h seen %h", n, x, a); end end

module tb_top;
    import ncq_pkg::*;

    logic         sys_clk;
    logic         reset;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         dma_req_valid;
    ncq_dma_req_t dma_req;
    logic         dma_req_ready;
    logic         cmpl_valid;
    ncq_cmpl_t    cmpl;
    logic         queue_full;
    logic         device_occupied_flag;
    logic         tx_valid;
    ncq_word_t    tx_word;
    logic         tx_ready;
    logic         stall;
    logic         issue_valid;
    logic [4:0]   issue_tag;
    logic [31:0]  q;
    logic         e;
    int           error_cnt;
    int           checked;
    ncq_dma_req_t tbl[4];

    ncq_fis_framer u_ncq_fis_framer
    (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma_req_valid(dma_req_valid), .dma_req(dma_req), .dma_req_ready(dma_req_ready),
        .cmpl_valid(cmpl_valid), .cmpl(cmpl), .queue_full(queue_full),
        .device_occupied_flag(device_occupied_flag), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready)
    );

    ncq_host_model u_ncq_host_model
    (
        .sys_clk(sys_clk), .reset(reset), .stall(stall), .issue_valid(issue_valid), .issue_tag(issue_tag),
        .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // --------------------
    // Bus and link tasks
    // --------------------
    // Access phase held until pready is seen at a rising edge; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic take_dma(input ncq_dma_req_t r);
        @(posedge sys_clk);
        dma_req_valid <= 1'b1;
        dma_req       <= r;
        do
        begin
            @(posedge sys_clk);
        end
        while (dma_req_ready !== 1'b1);
        dma_req_valid <= 1'b0;
    endtask

    task automatic wait_rx(input int t);
        int n;
        n = 0;
        while (u_ncq_host_model.rx.size() < t && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("frame words", t, u_ncq_host_model.rx.size())
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_regs();
        apb(1'b0, NCQ_REG_CTRL, 32'h0);
        `CHK("ctrl reset", {29'h0, NCQ_CTRL_RESET}, q)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 33'h100000000, {e, q})
        for (int i = 0; i < 2; i++)
        begin
            queue_full <= i[0];
            apb(1'b0, NCQ_REG_STATUS, 32'h0);
            `CHK("occupied pin", i[0], device_occupied_flag)
            `CHK("occupied reg", i[0], q[0])
        end
    endtask

    task automatic t_dma_frame(input ncq_dma_req_t r, input logic ofs);
        int b;
        logic [31:0] x[7];
        b = u_ncq_host_model.rx.size();
        x = '{{16'h0000, r.auto_act & ~r.dir, 1'b0, r.dir, 5'h00, NCQ_TYPE_DSETUP}, {27'h0, r.tag},
              32'h0, 32'h0, ofs ? r.offset : 32'h0, r.count, 32'h0};
        take_dma(r);
        wait_rx(b + 7);
        for (int i = 0; i < 7; i++)
            `CHK("setup word", x[i], u_ncq_host_model.rx[b + i])
    endtask

    task automatic t_zero();
        int b;
        b = u_ncq_host_model.rx.size();
        take_dma({1'b0, 1'b0, 5'h02, 32'h0, 32'h0});
        repeat (20) @(posedge sys_clk);
        `CHK("no frame", b, u_ncq_host_model.rx.size())
        apb(1'b0, NCQ_REG_STATUS, 32'h0);
        `CHK("zero seen", 1'b1, q[2])
        apb(1'b1, NCQ_REG_STATUS, 32'h4);
        apb(1'b0, NCQ_REG_STATUS, 32'h0);
        `CHK("zero cleared", 1'b0, q[2])
    endtask

    task automatic t_cmpl();
        logic [4:0]  tg[3];
        logic [31:0] m;
        int          b;
        int          n;
        tg = '{5'h03, 5'h1F, 5'h07};
        m = 32'h0;
        n = 0;
        b = u_ncq_host_model.rx.size();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            issue_valid <= i < 3;
            issue_tag   <= tg[i % 3];
        end
        // Back to back, last one failed
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            cmpl_valid <= i < 3;
            cmpl       <= {tg[i % 3], i != 2};
        end
        while (u_ncq_host_model.shadow_act !== 32'h80 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("shadow active", 32'h00000080, u_ncq_host_model.shadow_act)
        for (int i = b; i < u_ncq_host_model.rx.size(); i += 2)
        begin
            `CHK("sdb head", {NCQ_ERROR_OK, NCQ_STATUS_OK, 2'h1, 6'h00, NCQ_TYPE_SDB}, u_ncq_host_model.rx[i])
            m = m | u_ncq_host_model.rx[i + 1];
        end
        `CHK("mask union", 32'h80000008, m)
        `CHK("shadow status", 16'h0040, {u_ncq_host_model.shadow_err, u_ncq_host_model.shadow_stat})
        apb(1'b0, NCQ_REG_STATUS, 32'h0);
        `CHK("fail seen", 1'b1, q[3])
        apb(1'b0, NCQ_REG_PENDING, 32'h0);
        `CHK("pending", 32'h0, q)
    endtask

    task automatic summarize();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("Error watchdog expected done seen hang");
        summarize();
    end

    initial
    begin
        error_cnt = 0;
        checked = 0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {dma_req_valid, dma_req, cmpl_valid, cmpl} = '0;
        {queue_full, stall, issue_valid, issue_tag} = '0;
        tbl = '{{1'b1, 1'b1, 5'h1F, 32'h100, 32'h200}, {1'b0, 1'b1, 5'h00, 32'h40, 32'h1},
                {1'b1, 1'b0, 5'h0A, 32'hFFFFFFFC, 32'hFFFFFFFF}, {1'b0, 1'b1, 5'h15, 32'h8, 32'h10}};
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        stall <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                apb(1'b1, NCQ_REG_CTRL, 32'h7);
            t_dma_frame(tbl[i], i >= 2);
        end
        t_zero();
        t_cmpl();
        summarize();
    end
endmodule

`default_nettype wire
